// File: src/csi_pkg.sv
// codec serial interface: shared constants, field layout and carrier types
package csi_pkg;
    localparam int ADDR_W = 8;
    localparam int WORD_MAX = 16;
    localparam int SLOTS_MAX = 16;
    localparam int BUF_WORDS = 4;
    localparam int SYNC_W = 3;
    // register offsets (byte addresses)
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] FMT_OFS = 8'h04;
    localparam logic [7:0] STAT_OFS = 8'h08;
    localparam logic [7:0] BUF_OFS = 8'h10;
    localparam logic [7:0] BUF_MASK = 8'h0C;
    // control register fields
    localparam int EN_BIT = 0;
    localparam int BCK_DIR_BIT = 1;
    localparam int FS_DIR_BIT = 2;
    localparam int IDLE_MODE_BIT = 3;
    localparam int FS_MODE_POS = 4;
    // format register fields
    localparam int WS_POS = 0;
    localparam int BUFFER_LENGTH_SELECT_POS = 4;
    localparam int FLEN_POS = 8;
    localparam int DIV_POS = 16;
    // status register fields
    localparam int SLOT_POS = 0;
    localparam int RX_FULL_BIT = 4;
    localparam int TX_EMPTY_BIT = 5;
    // slot lengths of the two link framings
    localparam logic [4:0] AC16_SLOT = 5'h10;
    localparam logic [4:0] AC20_SLOT = 5'h14;

    typedef enum logic [1:0] {
        FS_MULTI = 2'h0,
        FS_I2S = 2'h1,
        FS_AC16 = 2'h2,
        FS_AC20 = 2'h3
    } csi_fs_mode_type;

    typedef enum logic [3:0] {
        PH_IDLE = 4'h1,
        PH_FETCH = 4'h2,
        PH_LOAD = 4'h4,
        PH_RUN = 4'h8
    } csi_phase_type;

    typedef struct packed {
        logic en;
        logic bit_clock_direction;
        logic frame_sync_direction;
        logic idle_output_mode;
        csi_fs_mode_type frame_sync_mode_select;
        logic [3:0] word_size_select;
        logic [1:0] buffer_length_select;
        logic [3:0] frame_len;
        logic [7:0] clk_div;
    } csi_cfg_type;

    // 16-bit words, one word per frame, bit clock toggles every 4 clocks
    localparam csi_cfg_type CFG_RST = '{1'b0, 1'b0, 1'b0, 1'b0, FS_MULTI,
                                        4'hF, 2'h0, 4'h0, 8'h03};
endpackage

// File: src/csi_buf_mem.sv
// shadow buffer memory: cpu port and serial-engine port, registered reads
module csi_buf_mem #(
    parameter int DW = 16,
    parameter int AW = 3
) (
    input wire logic clk,
    input wire logic a_we,
    input wire logic [AW-1:0] a_addr,
    input wire logic [DW-1:0] a_wd,
    output logic [DW-1:0] a_rd,
    input wire logic b_we,
    input wire logic [AW-1:0] b_waddr,
    input wire logic [DW-1:0] b_wd,
    input wire logic [AW-1:0] b_raddr,
    output logic [DW-1:0] b_rd
);
    logic [DW-1:0] mem [2**AW];

    // the cpu only writes the transmit half and the engine only the
    // receive half, so the two write ports never collide
    always_ff @(posedge clk)
    begin
        if (a_we)
        begin
            mem[a_addr] <= a_wd;
        end
        if (b_we)
        begin
            mem[b_waddr] <= b_wd;
        end
        a_rd <= mem[a_addr];
        b_rd <= mem[b_raddr];
    end
endmodule

// File: src/csi_core.sv
// codec serial interface: registers, pin control, framing and shift engine
// Behaviour
// RULE1: framed multi-channel, I2S and AC-link transfers
// RULE2: programmable word length, at most 16 bits
// RULE3: up to 16 slots, 256-bit frame (AC20 frames reach 320 bits: 16 slots of 20)
// RULE4: buffer up to four samples per direction
// RULE5: enabled port owns all four pin directions
// RULE6: bit clock driven or received per direction bit
// RULE7: serial out is output, driven during words
// RULE8: idle periods tri-stated or low per mode
// RULE9: serial in is input only when enabled
// RULE10: frame sync aligns data; direction bit selects driver
// RULE11: transfers go through shadow buffer memory
// RULE12: words left-justified in 16-bit buffers
// RULE13: short received words get zero LSBs
// RULE14: unused transmit LSBs are never sent
// RULE15: one 16-bit shift register, MSB first
// RULE16: two-bit mode selects multi, I2S, AC16, AC20
// RULE17: word length is field plus one bits
// RULE18: buffer length field selects one to four
// RULE19: one 2-bit word counter for both halves
// RULE20: slot counter advances, resets on frame sync
// RULE21: pulse request once buffered words exchanged
module csi_core #(
    parameter int ADDR_W = csi_pkg::ADDR_W
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic serial_bit_clock_pin_in,
    output logic serial_bit_clock_pin_out,
    output logic serial_bit_clock_pin_oe,
    output logic serial_out_pin_out,
    output logic serial_out_pin_oe,
    input wire logic serial_in_pin,
    input wire logic frame_sync_pin_in,
    output logic frame_sync_pin_out,
    output logic frame_sync_pin_oe,
    output logic block_done
);
    typedef struct packed {
        csi_pkg::csi_cfg_type cfg;
        logic [2:0] sy1;
        logic [2:0] sy2;
        logic [2:0] sy3;
        logic [2:0] cln;
        logic bck_prev;
        logic fs_prev;
        logic bck_gen;
        logic [7:0] div_cnt;
        logic fs_gen;
        logic [15:0] sr;
        logic [4:0] bitcnt;
        logic [3:0] slot;
        logic [1:0] wcnt;
        logic sdo;
        logic active;
        csi_pkg::csi_phase_type ph;
        logic wr;
        logic [2:0] wr_addr;
        logic [15:0] wr_data;
        logic done;
        logic rx_full;
        logic tx_empty;
        logic buf_rd;
        logic [31:0] rdata;
    } csi_state_type;

    csi_state_type q;
    csi_state_type d;
    logic [15:0] a_rd;
    logic [15:0] b_rd;
    logic [4:0] wl;
    logic [4:0] slot_len;
    logic [4:0] idx;
    logic [15:0] sr_in;
    logic [2:0] clean;
    logic bck_now;
    logic fs_now;
    logic rise;
    logic fall;
    logic fs_start;
    logic word_end;
    logic shift_en;
    logic hit_ctrl;
    logic hit_fmt;
    logic hit_stat;
    logic hit_buf;

    ////////////////////////////////////////////////////////////////////////
    // decode and timing terms

    assign hit_ctrl = reg_addr == ADDR_W'(csi_pkg::CTRL_OFS);
    assign hit_fmt = reg_addr == ADDR_W'(csi_pkg::FMT_OFS);
    assign hit_stat = reg_addr == ADDR_W'(csi_pkg::STAT_OFS);
    assign hit_buf = (reg_addr & ~ADDR_W'(csi_pkg::BUF_MASK)) == ADDR_W'(csi_pkg::BUF_OFS);

    assign wl = 5'(q.cfg.word_size_select) + 5'h1; // [RULE17] [RULE2]
    always_comb
    begin
        case (q.cfg.frame_sync_mode_select) // [RULE16] [RULE1]
            csi_pkg::FS_AC16: slot_len = csi_pkg::AC16_SLOT;
            csi_pkg::FS_AC20: slot_len = csi_pkg::AC20_SLOT;
            default: slot_len = wl;
        endcase
    end

    // a pin change counts once stages two and three agree; no fourth register,
    // so a data bit launched on a codec-driven clock still meets its next edge
    assign clean = (~(q.sy2 ^ q.sy3) & q.sy3) | ((q.sy2 ^ q.sy3) & q.cln);
    // internal clock and sync need no synchroniser when the device drives them
    assign bck_now = q.cfg.bit_clock_direction ? clean[0] : q.bck_gen; // [RULE6]
    assign fs_now = q.cfg.frame_sync_direction ? clean[1] : q.fs_gen; // [RULE10]
    assign rise = q.cfg.en & bck_now & ~q.bck_prev;
    assign fall = q.cfg.en & ~bck_now & q.bck_prev;
    // i2s frames open on the left channel, i.e. when sync drops
    assign fs_start = rise & ((q.cfg.frame_sync_mode_select == csi_pkg::FS_I2S)
                              ? (~fs_now & q.fs_prev) : (fs_now & ~q.fs_prev));
    assign idx = fs_start ? 5'h0 : q.bitcnt;
    assign word_end = rise & (idx == slot_len - 5'h1) & (q.ph == csi_pkg::PH_RUN);
    assign shift_en = rise & (idx < wl) & (q.ph == csi_pkg::PH_RUN);
    assign sr_in = shift_en ? {q.sr[14:0], clean[2]} : q.sr; // [RULE15]

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb
    begin
        d = q;
        d.sy1 = {serial_in_pin, frame_sync_pin_in, serial_bit_clock_pin_in};
        d.sy2 = q.sy1;
        d.sy3 = q.sy2;
        d.cln = clean;
        d.bck_prev = bck_now;
        d.wr = 1'b0;
        d.done = 1'b0;
        d.buf_rd = reg_rd & hit_buf;

        if (q.cfg.en && !q.cfg.bit_clock_direction)
        begin
            if (q.div_cnt == q.cfg.clk_div) // [RULE6]
            begin
                d.div_cnt = 8'h0;
                d.bck_gen = ~q.bck_gen;
            end
            else
            begin
                d.div_cnt = q.div_cnt + 8'h1;
            end
        end
        else
        begin
            d.div_cnt = 8'h0;
            d.bck_gen = 1'b0;
        end

        if (rise)
        begin
            d.fs_prev = fs_now;
            d.sr = sr_in;
            d.bitcnt = word_end ? 5'h0 : idx + 5'h1;
            if (fs_start)
            begin
                d.slot = 4'h0; // [RULE20]
                d.wcnt = 2'h0; // [RULE19]
            end
        end

        if (word_end)
        begin
            d.wr = 1'b1;
            d.wr_addr = {1'b0, q.wcnt}; // [RULE19]
            d.wr_data = sr_in << (5'h10 - wl); // [RULE12] [RULE13]
            d.slot = (q.slot == q.cfg.frame_len) ? 4'h0 : q.slot + 4'h1; // [RULE20] [RULE3]
            d.done = q.wcnt == q.cfg.buffer_length_select; // [RULE18] [RULE21] [RULE4]
            d.wcnt = d.done ? 2'h0 : q.wcnt + 2'h1; // [RULE19]
            d.ph = csi_pkg::PH_FETCH;
        end

        if (fall)
        begin
            // bits beyond the word length stay idle: short words never
            // reach the pin from the unused low end of the buffer
            d.active = q.bitcnt < wl && q.ph == csi_pkg::PH_RUN; // [RULE14] [RULE7]
            d.sdo = d.active & q.sr[15]; // [RULE15] [RULE8]
            case (q.cfg.frame_sync_mode_select)
                csi_pkg::FS_MULTI: d.fs_gen = q.slot == 4'h0 && q.bitcnt == 5'h0;
                csi_pkg::FS_I2S: d.fs_gen = q.slot[0];
                default: d.fs_gen = q.slot == 4'h0;
            endcase
        end

        case (q.ph)
            csi_pkg::PH_IDLE:
            begin
                d.wcnt = 2'h0;
                d.slot = 4'h0;
                d.bitcnt = 5'h0;
                d.active = 1'b0;
                d.sdo = 1'b0;
                d.fs_gen = 1'b0;
                if (q.cfg.en)
                begin
                    d.ph = csi_pkg::PH_FETCH;
                end
            end
            csi_pkg::PH_FETCH: d.ph = csi_pkg::PH_LOAD;
            csi_pkg::PH_LOAD:
            begin
                d.sr = b_rd; // [RULE11]
                d.ph = csi_pkg::PH_RUN;
            end
            csi_pkg::PH_RUN: d.ph = word_end ? csi_pkg::PH_FETCH : csi_pkg::PH_RUN;
            default: d.ph = csi_pkg::PH_IDLE;
        endcase
        if (!q.cfg.en)
        begin
            d.ph = csi_pkg::PH_IDLE;
        end

        // a block end in the same cycle as the clearing access wins
        d.rx_full = d.done | (q.rx_full & ~(reg_rd & hit_buf));
        d.tx_empty = d.done | (q.tx_empty & ~(reg_wr & hit_buf));

        if (reg_wr && hit_ctrl)
        begin
            d.cfg.en = reg_wdata[csi_pkg::EN_BIT];
            d.cfg.bit_clock_direction = reg_wdata[csi_pkg::BCK_DIR_BIT];
            d.cfg.frame_sync_direction = reg_wdata[csi_pkg::FS_DIR_BIT];
            d.cfg.idle_output_mode = reg_wdata[csi_pkg::IDLE_MODE_BIT];
            d.cfg.frame_sync_mode_select =
                csi_pkg::csi_fs_mode_type'(reg_wdata[csi_pkg::FS_MODE_POS +: 2]);
        end
        if (reg_wr && hit_fmt)
        begin
            d.cfg.word_size_select = reg_wdata[csi_pkg::WS_POS +: 4];
            d.cfg.buffer_length_select = reg_wdata[csi_pkg::BUFFER_LENGTH_SELECT_POS +: 2];
            d.cfg.frame_len = reg_wdata[csi_pkg::FLEN_POS +: 4];
            d.cfg.clk_div = reg_wdata[csi_pkg::DIV_POS +: 8];
        end

        d.rdata = 32'h0;
        if (reg_rd && hit_ctrl)
        begin
            d.rdata[csi_pkg::EN_BIT] = q.cfg.en;
            d.rdata[csi_pkg::BCK_DIR_BIT] = q.cfg.bit_clock_direction;
            d.rdata[csi_pkg::FS_DIR_BIT] = q.cfg.frame_sync_direction;
            d.rdata[csi_pkg::IDLE_MODE_BIT] = q.cfg.idle_output_mode;
            d.rdata[csi_pkg::FS_MODE_POS +: 2] = q.cfg.frame_sync_mode_select;
        end
        if (reg_rd && hit_fmt)
        begin
            d.rdata[csi_pkg::WS_POS +: 4] = q.cfg.word_size_select;
            d.rdata[csi_pkg::BUFFER_LENGTH_SELECT_POS +: 2] = q.cfg.buffer_length_select;
            d.rdata[csi_pkg::FLEN_POS +: 4] = q.cfg.frame_len;
            d.rdata[csi_pkg::DIV_POS +: 8] = q.cfg.clk_div;
        end
        if (reg_rd && hit_stat)
        begin
            d.rdata[csi_pkg::SLOT_POS +: 4] = q.slot;
            d.rdata[csi_pkg::RX_FULL_BIT] = q.rx_full;
            d.rdata[csi_pkg::TX_EMPTY_BIT] = q.tx_empty;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            q <= '0;
            q.cfg <= csi_pkg::CFG_RST;
            q.ph <= csi_pkg::PH_IDLE;
        end
        else
        begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // shadow memory: receive half at 0..3, transmit half at 4..7

    csi_buf_mem #(
        .DW(csi_pkg::WORD_MAX),
        .AW(3)
    ) u_mem (
        .clk(ref_clk),
        .a_we(reg_wr & hit_buf),
        .a_addr({reg_wr, reg_addr[3:2]}),
        .a_wd(reg_wdata[15:0]),
        .a_rd(a_rd),
        .b_we(q.wr),
        .b_waddr(q.wr_addr),
        .b_wd(q.wr_data),
        .b_raddr({1'b1, q.wcnt}),
        .b_rd(b_rd)
    );

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign reg_rdata = q.buf_rd ? {16'h0, a_rd} : q.rdata;
    // a disabled port releases every pin; serial in is never driven
    assign serial_bit_clock_pin_out = q.bck_gen;
    assign serial_bit_clock_pin_oe = q.cfg.en & ~q.cfg.bit_clock_direction; // [RULE5] [RULE6]
    assign frame_sync_pin_out = q.fs_gen;
    assign frame_sync_pin_oe = q.cfg.en & ~q.cfg.frame_sync_direction; // [RULE5] [RULE10]
    assign serial_out_pin_out = q.sdo;
    assign serial_out_pin_oe = q.cfg.en & (q.active | ~q.cfg.idle_output_mode); // [RULE7] [RULE8]
    assign block_done = q.done; // [RULE21]

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    pins_released_a: assert property (!q.cfg.en |-> // [RULE5] [RULE9]
        !serial_bit_clock_pin_oe && !serial_out_pin_oe && !frame_sync_pin_oe)
        else $error("pin driven while port disabled");
    bck_direction_a: assert property ($rose(q.cfg.en) |-> // [RULE6]
        serial_bit_clock_pin_oe == !q.cfg.bit_clock_direction)
        else $error("bit clock direction wrong");
    fs_direction_a: assert property (q.cfg.en |-> // [RULE10]
        frame_sync_pin_oe != q.cfg.frame_sync_direction)
        else $error("frame sync direction wrong");
    word_drive_a: assert property (fall && q.bitcnt < wl && q.ph == csi_pkg::PH_RUN // [RULE7]
        |=> serial_out_pin_oe)
        else $error("serial out not driven during word");
    idle_low_a: assert property (q.cfg.en && !q.active && !q.cfg.idle_output_mode // [RULE8]
        |-> serial_out_pin_oe && !serial_out_pin_out)
        else $error("idle period not driven low");
    msb_first_a: assert property (fall && q.bitcnt < wl && q.ph == csi_pkg::PH_RUN // [RULE15]
        |=> serial_out_pin_out == $past(q.sr[15]))
        else $error("serial out not shift register msb");
    rx_zero_lsb_a: assert property (q.wr |-> // [RULE13]
        (q.wr_data & (16'hFFFF >> wl)) == 16'h0)
        else $error("received word has nonzero low bits");
    slot_restart_a: assert property (fs_start && !word_end |=> q.slot == 4'h0) // [RULE20]
        else $error("slot not reset by frame sync");
    block_count_a: assert property (word_end |=> // [RULE21] [RULE19]
        q.done == ($past(q.wcnt) == q.cfg.buffer_length_select) ##1 !q.done)
        else $error("block pulse at wrong word count");
    load_order_a: assert property (q.ph == csi_pkg::PH_FETCH && q.cfg.en // [RULE11]
        |=> q.ph == csi_pkg::PH_LOAD ##1 q.sr == $past(b_rd))
        else $error("shadow word not loaded");

    block_cov: cover property (block_done);
    i2s_frame_cov: cover property (fs_start
        && q.cfg.frame_sync_mode_select == csi_pkg::FS_I2S);
    ac20_word_cov: cover property (word_end
        && q.cfg.frame_sync_mode_select == csi_pkg::FS_AC20);
    four_words_cov: cover property (block_done && q.cfg.buffer_length_select == 2'h3);
endmodule

// File: bench/csi_codec_model.sv
// external codec model: clock and sync source, serial capture and playback
module csi_codec_model (
    input wire logic drive_clk,
    input wire logic i2s,
    input wire logic [4:0] wl,
    input wire logic [4:0] sw,
    input wire logic [2:0] slots,
    input wire logic [63:0] send,
    input wire logic bck,
    input wire logic fs,
    input wire logic sdo,
    input wire logic sdo_oe,
    output logic bck_out,
    output logic fs_out,
    output logic sdi,
    output logic [63:0] got,
    output int fs_len,
    output int frm_bits,
    output int oe_bits,
    output int frames
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt;
    int gen;
    int fs_run;
    int oe_run;
    int idx;
    logic fs_prev;
    logic [63:0] cur;
    initial
    begin
        {bck_out, fs_out, sdi, fs_prev, got, cur} = '0;
        {cnt, gen, fs_run, oe_run, fs_len, frm_bits, oe_bits, frames} = '0;
        forever
        begin
            #80;
            bck_out = drive_clk ? !bck_out : 1'b0;
        end
    end
    ////////////////////////////////////////////////////////////////
    // frame starts on the sync edge; i2s frames start where sync falls
    always @(posedge bck)
    begin
        if (fs != fs_prev && fs != i2s)
        begin
            // words are handed over only once their frame is complete
            got = cur;
            frm_bits = cnt;
            oe_bits = oe_run;
            fs_len = fs_run;
            frames++;
            cnt = 0;
            oe_run = 0;
            fs_run = 0;
        end
        fs_prev = fs;
        fs_run += int'(fs);
        oe_run += int'(sdo_oe);
        if (cnt / sw < 4 && cnt % sw == 0)
            cur[(cnt / sw) * 16 +: 16] = '0;
        if (sdo_oe && cnt / sw < 4 && cnt % sw < wl)
            cur[(cnt / sw) * 16 + 15 - cnt % sw] = sdo;
        cnt++;
    end
    // bits past the word toggle so a lazy sampler cannot pass by luck
    always @(negedge bck)
    begin
        if (drive_clk)
        begin
            fs_out = (gen == 0);
            idx = gen;
            gen = (gen + 1) % (int'(slots) * int'(sw));
        end
        else
            idx = cnt % (int'(slots) * int'(sw));
        if (idx % sw < wl)
            sdi = send[(idx / sw) * 16 + 15 - idx % sw];
        else
            sdi = !sdi;
    end
endmodule

// File: bench/tb_top.sv
// self-checking bench for the codec serial interface
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk, rst, reg_wr, reg_rd, drive_clk, i2s;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic bck_o, bck_oe, sdo_o, sdo_oe, fs_o, fs_oe, done, p_bck, p_fs, p_sdi;
    logic [4:0] wl, sw;
    logic [3:0] ws;
    logic [2:0] slots;
    logic [63:0] send, got;
    int fs_len, frm_bits, oe_bits, frames, f0, bad_count, n_checks, cyc, m, k;
    wire logic bck_w = bck_oe ? bck_o : p_bck;
    wire logic fs_w = fs_oe ? fs_o : p_fs;
    // released data line sits on a pull-down
    wire logic sdo_w = sdo_oe ? sdo_o : 1'b0;

    csi_core dut (.ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .serial_bit_clock_pin_in(bck_w), .serial_bit_clock_pin_out(bck_o),
        .serial_bit_clock_pin_oe(bck_oe), .serial_out_pin_out(sdo_o),
        .serial_out_pin_oe(sdo_oe), .serial_in_pin(p_sdi), .frame_sync_pin_in(fs_w),
        .frame_sync_pin_out(fs_o), .frame_sync_pin_oe(fs_oe), .block_done(done));

    csi_codec_model codec (.drive_clk, .i2s, .wl, .sw, .slots, .send, .bck(bck_w),
        .fs(fs_w), .sdo(sdo_w), .sdo_oe, .bck_out(p_bck), .fs_out(p_fs), .sdi(p_sdi),
        .got, .fs_len, .frm_bits, .oe_bits, .frames);

    ////////////////////////////////////////////////////////////////
    initial
    begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            bad_count++;
            end_sim();
        end
    end

    task end_sim();
        if (bad_count == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task chk(string name, logic [31:0] exp, logic [31:0] g);
        n_checks++;
        if (g !== exp)
        begin
            $display("Error %s expected %h seen %h", name, exp, g);
            bad_count++;
        end
    endtask

    task wr(logic [7:0] a, logic [31:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    task rd(logic [7:0] a, logic [31:0] exp, logic [31:0] msk, string name);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 chk(name, exp, reg_rdata & msk);
    endtask

    task wait_done();
        k = 0;
        do
        begin
            @(posedge ref_clk);
            k++;
        end
        while (done !== 1'b1 && k < 4000);
        chk("block_done", 1, done);
    endtask

    task wait_frames(int n);
        k = 0;
        while (frames < n && k < 20000)
        begin
            @(posedge ref_clk);
            k++;
        end
        chk("frames", 1, frames >= n);
    endtask

    // word as the buffer must hold it: left-justified, low bits zero
    function logic [15:0] just(logic [15:0] v, int l);
        return v & ~(16'hFFFF >> l);
    endfunction

    task fill_tx();
        send = {$urandom, $urandom};
        for (k = 0; k < 4; k++)
            wr(csi_pkg::BUF_OFS + 8'(4 * k), {16'h0, send[k * 16 +: 16]});
    endtask

    task check_words(int n);
        for (m = 0; m < n; m++)
            chk("tx word", just(send[m * 16 +: 16], wl), got[m * 16 +: 16]);
        wait_done();
        wait_done();
        for (m = 0; m < n; m++)
            rd(csi_pkg::BUF_OFS + 8'(4 * m), just(send[m * 16 +: 16], wl), 32'hFFFFFFFF, "rx word");
    endtask

    ////////////////////////////////////////////////////////////////
    initial
    begin
        {rst, drive_clk, i2s, reg_wr, reg_rd, reg_addr, reg_wdata} = {1'b1, 44'h0};
        {wl, sw, slots, send, bad_count, n_checks, cyc} = {5'h10, 5'h10, 3'h2, 64'h0, 96'h0};
        void'($urandom(34));
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        chk("pin enables", 3'h0, {bck_oe, sdo_oe, fs_oe});
        rd(csi_pkg::CTRL_OFS, 32'h0, 32'hFFFFFFFF, "ctrl");
        rd(csi_pkg::FMT_OFS, 32'h0003000F, 32'hFFFFFFFF, "fmt");
        rd(csi_pkg::STAT_OFS, 32'h0, 32'hFFFFFFFF, "stat");
        wr(8'h24, 32'hFFFFFFFF);
        rd(8'h24, 32'h0, 32'hFFFFFFFF, "unmapped");
        // device drives clock and sync; every framing, unused bits tri-stated
        for (int fm = 0; fm < 4; fm++)
        begin
            fill_tx();
            ws = 4'(3 + $urandom % 13);
            wl = 5'(ws) + 5'h1;
            i2s = (fm == 1);
            sw = fm == 2 ? 5'h10 : fm == 3 ? 5'h14 : wl;
            wr(csi_pkg::FMT_OFS, 32'h00030110 | ws);
            wr(csi_pkg::CTRL_OFS, 32'h9 | (fm << 4));
            f0 = frames;
            wait_frames(f0 + 3);
            chk("bck enable", 1, bck_oe);
            chk("fs enable", 1, fs_oe);
            chk("frame bits", 2 * sw, frm_bits);
            chk("sync bits", fm == 0 ? 1 : fm == 1 ? wl : sw, fs_len);
            chk("driven bits", 2 * wl, oe_bits);
            check_words(2);
            wr(csi_pkg::CTRL_OFS, 32'h0);
            #1 chk("pin enables", 3'h0, {bck_oe, sdo_oe, fs_oe});
        end
        // codec drives clock and sync, four slots buffered, idle bits low
        fill_tx();
        ws = 4'(3 + $urandom % 13);
        wl = 5'(ws) + 5'h1;
        sw = wl;
        i2s = 1'b0;
        slots = 3'h4;
        drive_clk <= 1'b1;
        wr(csi_pkg::FMT_OFS, 32'h00030330 | ws);
        wr(csi_pkg::CTRL_OFS, 32'h7);
        f0 = frames;
        wait_frames(f0 + 3);
        chk("bck enable", 0, bck_oe);
        chk("fs enable", 0, fs_oe);
        chk("sdo enable", 1, sdo_oe);
        chk("frame bits", 4 * wl, frm_bits);
        check_words(4);
        wait_done();
        #1 rd(csi_pkg::STAT_OFS, 32'h30, 32'h30, "block flags");
        end_sim();
    end
endmodule
